/* hdl/spc_defines.svh */
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
// Program store geometry
`define SPC_PROG_DEPTH 16
`define SPC_PC_W 4
// Command buffer geometry and flow thresholds
`define SPC_FIFO_DEPTH 8
`define SPC_FIFO_AW 3
`define SPC_FLOW_HI 4'h6
`define SPC_FLOW_LO 4'h2
// Characters sent on the serial reply
`define SPC_CH_XON 8'h11
`define SPC_CH_XOFF 8'h13
`define SPC_CH_CR 8'h0D
`define SPC_CH_LF 8'h0A
`define SPC_CH_MARK 8'h2A
`define SPC_CH_ZERO 8'h30
`define SPC_CH_LOWA 8'h61
`define SPC_END_TXT 32'h656E643A
`endif

/* hdl/spc_pkg.sv */
package spc_pkg;
    // Decoded command opcodes
    typedef enum logic [4:0] {
        op_nop, op_clear_pin_low_cmd, op_set_pin_high, op_flip_pin_cmd,
        op_fault_pin_output_mode, op_begin_program_capture, op_end_marker,
        op_read_back_program, op_run_program, op_halt_program, op_resume,
        op_mem_query, op_wait_position_reached, op_wait_limit_switch,
        op_wait_speed_reached, op_move, op_velocity, op_homing_sequence_run,
        op_hall_null_search, op_persist_settings
    } spc_op_t;
    // Command as delivered by the line decoder
    typedef struct packed {
        logic addressed;
        logic [7:0] node;
        spc_op_t op;
        logic [15:0] arg;
    } spc_cmd_t;
    // One stored program line, also the motion request
    typedef struct packed {
        spc_op_t op;
        logic [15:0] arg;
    } spc_line_t;
    // Interpreter modes
    typedef enum logic [2:0] {
        st_exec = 3'b001,
        st_capt = 3'b010,
        st_read = 3'b100
    } spc_state_t;
endpackage : spc_pkg

/* hdl/spc_ctrl.sv */
`timescale 1ns/100ps
// Functional notes
// - Pin is digital output only in that mode
// - Entering digital output mode drives pin low
// - Clear command drives pin low
// - Set command drives pin high
// - Toggle command inverts pin level
// - During capture commands are stored, not executed
// - After end marker commands execute again
// - End marker commits program without save
// - Long transfers use Xon/Xoff flow control
// - Argument 1 marks program counter line
// - Run command starts the stored program
// - Saved enable starts program after power-up
// - Halt keeps point; resume continues there
// - Memory query returns free words
// - Host commands still served while running
// - Only addressed node stores the capture
// - Position notify pauses at move until reached
// - Limit notify pauses at homing or move
// - Speed notify pauses at move until reached
// - Hall search pauses until null reached
// - First fulfilled notify continues program
`include "spc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module spc_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    output logic [AW:0] level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr, rd, next_wr, next_rd;
    logic [AW:0] next_level;
    logic push, pop;

    // Pointer and level update; depth must be a power of two
    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr = push ? wr + 1'b1 : wr;
        next_rd = pop ? rd + 1'b1 : rd;
        next_level = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr <= '0;
            rd <= '0;
            level <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            wr <= next_wr;
            rd <= next_rd;
            level <= next_level;
            in_ready <= next_level != (AW+1)'(DEPTH);
            out_valid <= next_level != '0;
        end
    end

    // Storage carries no reset
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wr] <= in_data;
    end

    assign out_data = mem[rd];
endmodule : spc_fifo

////////////////////////////////////////////////////////////////////////////////
module spc_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Command stream from line decoder
    input wire logic cmd_valid,
    input wire spc_pkg::spc_cmd_t cmd,
    output logic cmd_ready,
    // Node identity and saved start flag
    input wire logic [7:0] node_id,
    input wire logic autorun_saved,
    // Motion requests and notify conditions
    output logic motion_valid,
    output spc_pkg::spc_line_t motion,
    input wire logic pos_reached,
    input wire logic limit_passed,
    input wire logic speed_reached,
    input wire logic hall_null,
    // Fault pin
    input wire logic err_level,
    output logic fault_pin,
    // Serial reply bytes
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    input wire logic host_paused,
    // Status and nonvolatile requests
    output logic mem_free_valid,
    output logic [4:0] mem_free,
    output logic nv_commit,
    output logic nv_save,
    output logic nv_run_enable,
    output logic prog_running,
    output logic prog_waiting
);
    import spc_pkg::*;

    spc_line_t prog [`SPC_PROG_DEPTH];
    spc_state_t st, next_st;
    spc_cmd_t hc;
    spc_line_t cur, next_motion;
    spc_op_t op;
    logic [15:0] arg;
    logic [4:0] pc, next_pc, len, next_len, cap, next_cap, rd_line, next_rd_line;
    logic [4:0] next_mem_free;
    logic [5:0] lenb;
    logic [3:0] wmask, next_wmask, events;
    logic [2:0] arm, next_arm, tail, next_tail;
    logic [1:0] ph, next_ph;
    logic [7:0] next_tx_byte;
    logic [`SPC_FIFO_AW:0] f_level;
    logic f_valid, f_ready, host_go, for_me, step, go, prg, wr_en;
    logic next_running, dig_mode, next_dig_mode, dout, next_dout, mark, next_mark;
    logic xoff_sent, next_xoff_sent, boot, next_boot, next_tx_valid, next_fault_pin;
    logic next_motion_valid, next_mem_free_valid, next_nv_commit, next_nv_save;
    logic next_nv_run_enable, next_prog_waiting;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    spc_fifo #(.WIDTH($bits(spc_cmd_t)), .DEPTH(`SPC_FIFO_DEPTH), .AW(`SPC_FIFO_AW)) u_buf (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(cmd_valid),
        .in_data(cmd),
        .in_ready(cmd_ready),
        .out_valid(f_valid),
        .out_data(hc),
        .out_ready(f_ready),
        .level(f_level)
    );

    // Closing line characters: "end:", two length digits, CR, LF
    function automatic logic [7:0] tail_char(input logic [2:0] i, input logic [5:0] n);
        logic [5:0] q;
        q = 6'(n / 6'h0A);
        unique case (i)
            3'h4: tail_char = `SPC_CH_ZERO + {2'h0, q};
            3'h5: tail_char = `SPC_CH_ZERO + {2'h0, 6'(n % 6'h0A)};
            3'h6: tail_char = `SPC_CH_CR;
            3'h7: tail_char = `SPC_CH_LF;
            default: tail_char = 8'(`SPC_END_TXT >> (8 * (3 - i)));
        endcase
    endfunction : tail_char

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole interpreter
    always_comb
    begin
        next_st = st;
        {next_pc, next_len, next_cap, next_rd_line} = {pc, len, cap, rd_line};
        {next_wmask, next_arm, next_tail, next_ph, next_mark} = {wmask, arm, tail, ph, mark};
        {next_running, next_dig_mode, next_dout} = {prog_running, dig_mode, dout};
        {next_xoff_sent, next_boot, next_mem_free} = {xoff_sent, 1'b1, mem_free};
        next_tx_valid = tx_valid && !tx_ready;
        next_tx_byte = tx_byte;
        next_motion = motion;
        {next_motion_valid, next_mem_free_valid, next_nv_commit, next_nv_save} = 4'h0;
        next_nv_run_enable = nv_run_enable;
        events = {pos_reached, limit_passed, speed_reached, hall_null};
        cur = prog[pc[3:0]];
        lenb = {len, 1'b0} + {5'h0, mark && pc < len};
        for_me = !hc.addressed || hc.node == node_id;
        f_ready = st != st_read;
        host_go = f_valid && f_ready && for_me;
        // Host commands win a cycle over the program
        step = prog_running && wmask == 4'h0 && !host_go && st == st_exec;
        go = 1'b0;
        prg = 1'b0;
        wr_en = 1'b0;
        op = op_nop;
        arg = 16'h0;
        // Saved enable starts the program once
        if (!boot)
        begin
            next_running = autorun_saved && len != 5'h0;
            next_pc = 5'h0;
        end
        // Any armed condition met releases the wait
        if ((wmask & events) != 4'h0)
            next_wmask = 4'h0;
        // Capture stores lines without executing them
        if (host_go && st == st_capt)
        begin
            if (hc.op == op_end_marker)
            begin
                next_st = st_exec;
                next_len = cap;
                // Commit happens without a save command
                next_nv_commit = 1'b1;
            end
            else if (cap < 5'(`SPC_PROG_DEPTH))
            begin
                wr_en = 1'b1;
                next_cap = cap + 5'h1;
            end
        end
        else if (host_go && st == st_exec)
        begin
            go = 1'b1;
            op = hc.op;
            arg = hc.arg;
        end
        else if (step)
        begin
            go = 1'b1;
            prg = 1'b1;
            op = cur.op;
            arg = cur.arg;
            next_pc = pc + 5'h1;
            next_running = pc + 5'h1 < len;
        end
        if (go)
        begin
            unique case (op)
                op_clear_pin_low_cmd: next_dout = dig_mode ? 1'b0 : dout;
                op_set_pin_high: next_dout = dig_mode ? 1'b1 : dout;
                op_flip_pin_cmd: next_dout = dig_mode ? !dout : dout;
                op_fault_pin_output_mode:
                begin
                    next_dig_mode = arg[0];
                    next_dout = 1'b0;
                end
                op_begin_program_capture:
                begin
                    next_st = st_capt;
                    next_cap = 5'h0;
                    next_running = 1'b0;
                    next_wmask = 4'h0;
                end
                op_read_back_program:
                begin
                    next_st = st_read;
                    next_rd_line = 5'h0;
                    next_ph = 2'h0;
                    next_tail = 3'h0;
                    next_mark = arg[0];
                end
                op_run_program:
                begin
                    next_running = len != 5'h0;
                    next_pc = 5'h0;
                    next_wmask = 4'h0;
                end
                op_halt_program:
                begin
                    next_running = 1'b0;
                    next_wmask = 4'h0;
                end
                op_resume: next_running = pc < len;
                op_mem_query:
                begin
                    next_mem_free = 5'(`SPC_PROG_DEPTH) - len;
                    next_mem_free_valid = 1'b1;
                end
                op_persist_settings:
                begin
                    next_nv_save = 1'b1;
                    next_nv_run_enable = prog_running;
                end
                op_wait_position_reached: next_arm[2] = arm[2] || prg;
                op_wait_limit_switch: next_arm[1] = arm[1] || prg;
                op_wait_speed_reached: next_arm[0] = arm[0] || prg;
                op_move, op_velocity, op_homing_sequence_run, op_hall_null_search:
                begin
                    next_motion_valid = 1'b1;
                    next_motion = '{op: op, arg: arg};
                    if (prg)
                    begin
                        next_arm = 3'h0;
                        if (op == op_move || op == op_velocity)
                            next_wmask = {arm, 1'b0};
                        else if (op == op_homing_sequence_run)
                            next_wmask = {1'b0, arm[1], 2'h0};
                        else
                            next_wmask = 4'h1;
                    end
                end
                default:
                begin
                end
            endcase
        end
        // Flow characters take priority on the reply
        if (!next_tx_valid)
        begin
            if (f_level >= `SPC_FLOW_HI && !xoff_sent)
            begin
                {next_tx_valid, next_tx_byte, next_xoff_sent} = {1'b1, `SPC_CH_XOFF, 1'b1};
            end
            else if (f_level <= `SPC_FLOW_LO && xoff_sent)
            begin
                {next_tx_valid, next_tx_byte, next_xoff_sent} = {1'b1, `SPC_CH_XON, 1'b0};
            end
            else if (st == st_read && !host_paused)
            begin
                unique case (ph)
                    2'h0:
                    begin
                        next_ph = rd_line == len ? 2'h3 : 2'h1;
                        if (rd_line != len && mark && rd_line == pc)
                            {next_tx_valid, next_tx_byte} = {1'b1, `SPC_CH_MARK};
                    end
                    2'h1:
                    begin
                        next_tx_byte = `SPC_CH_LOWA + {3'h0, prog[rd_line[3:0]].op};
                        next_tx_valid = 1'b1;
                        next_ph = 2'h2;
                    end
                    2'h2:
                    begin
                        {next_tx_valid, next_tx_byte} = {1'b1, `SPC_CH_CR};
                        next_rd_line = rd_line + 5'h1;
                        next_ph = 2'h0;
                    end
                    2'h3:
                    begin
                        {next_tx_valid, next_tx_byte} = {1'b1, tail_char(tail, lenb)};
                        next_tail = tail + 3'h1;
                        if (tail == 3'h7)
                            next_st = st_exec;
                    end
                endcase
            end
        end
        // Pin follows the error level outside digital mode
        next_fault_pin = next_dig_mode ? next_dout : err_level;
        next_prog_waiting = next_wmask != 4'h0;
    end

    // Register stage; outputs other than cmd_ready come straight from here
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= st_exec;
            {pc, cap, rd_line, wmask, arm, tail, ph, mark} <= 28'h0;
            {prog_running, dig_mode, dout, xoff_sent, boot, fault_pin} <= 6'h0;
            {tx_valid, tx_byte, motion_valid} <= 10'h0;
            motion <= '0;
            {mem_free_valid, mem_free, nv_commit, nv_save, nv_run_enable} <= 9'h0;
            prog_waiting <= 1'b0;
        end
        else
        begin
            st <= next_st;
            {pc, cap, rd_line, wmask} <= {next_pc, next_cap, next_rd_line, next_wmask};
            {arm, tail, ph, mark} <= {next_arm, next_tail, next_ph, next_mark};
            {prog_running, dig_mode, dout} <= {next_running, next_dig_mode, next_dout};
            {xoff_sent, boot, fault_pin} <= {next_xoff_sent, next_boot, next_fault_pin};
            {tx_valid, tx_byte, motion_valid, motion} <=
                {next_tx_valid, next_tx_byte, next_motion_valid, next_motion};
            {mem_free_valid, mem_free} <= {next_mem_free_valid, next_mem_free};
            {nv_commit, nv_save} <= {next_nv_commit, next_nv_save};
            nv_run_enable <= next_nv_run_enable;
            prog_waiting <= next_prog_waiting;
        end
    end

    // Program store and length survive nrst, standing in for flash
    always_ff @(posedge mclk)
    begin
        len <= next_len;
        if (wr_en)
            prog[cap[3:0]] <= '{op: hc.op, arg: hc.arg};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_pin_clear_low: assert property (
        go && op == op_clear_pin_low_cmd && dig_mode |=> !fault_pin)
        else $error("clear did not drive pin low");
    a_pin_set_high: assert property (
        go && op == op_set_pin_high && dig_mode |=> fault_pin)
        else $error("set did not drive pin high");
    a_pin_flip_inv: assert property (
        go && op == op_flip_pin_cmd && dig_mode |=> fault_pin != $past(fault_pin))
        else $error("toggle did not invert pin");
    a_mode_enter_low: assert property (
        go && op == op_fault_pin_output_mode && arg[0] |=> dig_mode && !fault_pin)
        else $error("digital mode did not start low");
    a_pin_err_follow: assert property (
        !next_dig_mode |=> fault_pin == $past(err_level))
        else $error("pin left error level outside digital mode");
    a_capture_no_motion: assert property (
        st == st_capt ##1 st == st_capt |-> !motion_valid)
        else $error("command executed during capture");
    a_end_commit: assert property (
        host_go && st == st_capt && hc.op == op_end_marker
        |=> nv_commit && st == st_exec ##1 !nv_commit)
        else $error("end marker not committed");
    // A halt read from the store steps past its own line on purpose
    a_halt_keep_pc: assert property (
        go && !prg && op == op_halt_program |=> !prog_running && pc == $past(pc))
        else $error("halt lost the program counter");
    a_mem_free_val: assert property (
        go && op == op_mem_query |=> mem_free_valid && mem_free == 5'(`SPC_PROG_DEPTH) - len)
        else $error("bad free count");
    a_notify_release: assert property (
        wmask != 4'h0 && (wmask & events) != 4'h0 |=> wmask == 4'h0)
        else $error("met notify did not release program");
    c_capture_done: cover property (st == st_capt ##[1:50] nv_commit);
    c_program_waits: cover property (prog_waiting ##[1:50] !prog_waiting);
    c_readback_end: cover property (st == st_read ##[1:200] st == st_exec);
    c_flow_xoff: cover property (tx_valid && tx_byte == `SPC_CH_XOFF);
endmodule : spc_ctrl

/* dv/spc_host_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Host end of the reply stream: collects payload bytes, may stall and pause
module spc_host_model (
    // Clock
    input wire logic mclk,
    // Reply stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready,
    output logic host_paused,
    // Pacing chosen by the bench
    input wire logic slow
);
    logic [7:0] rx_q[$];
    logic [3:0] tick;
    initial
    begin
        tx_ready = 1'b0;
        host_paused = 1'b0;
        tick = 4'h0;
    end
    // Host pacing from slow and a free-running tick
    // Flow characters are not payload, so they stay out of the queue
    always @(posedge mclk)
    begin
        if (tx_valid && tx_ready && tx_byte != 8'h11 && tx_byte != 8'h13)
            rx_q.push_back(tx_byte);
        tick <= tick + 4'h1;
        tx_ready <= !slow || tick[0];
        host_paused <= slow && tick[3:2] == 2'b11;
    end
endmodule : spc_host_model

/* dv/tb_top.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module tb_top;
    import spc_pkg::*;
    logic mclk, nrst, cmd_valid, cmd_ready, autorun_saved, motion_valid, slow;
    spc_cmd_t cmd;
    spc_line_t motion;
    logic [7:0] node_id, tx_byte;
    logic pos_reached, limit_passed, speed_reached, hall_null, err_level, fault_pin;
    logic tx_valid, tx_ready, host_paused, mem_free_valid, nv_commit, nv_save;
    logic nv_run_enable, prog_running, prog_waiting;
    logic [4:0] mem_free;
    int fail_count, compares;

    spc_ctrl dut (.mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .node_id(node_id), .autorun_saved(autorun_saved),
        .motion_valid(motion_valid), .motion(motion), .pos_reached(pos_reached),
        .limit_passed(limit_passed), .speed_reached(speed_reached), .hall_null(hall_null),
        .err_level(err_level), .fault_pin(fault_pin), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready), .host_paused(host_paused),
        .mem_free_valid(mem_free_valid), .mem_free(mem_free), .nv_commit(nv_commit),
        .nv_save(nv_save), .nv_run_enable(nv_run_enable), .prog_running(prog_running),
        .prog_waiting(prog_waiting));
    spc_host_model host (.mclk(mclk), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .host_paused(host_paused), .slow(slow));

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task close_out;
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Offer one command, hold it until taken, then let an edge pass
    task send(input spc_op_t op, input logic [15:0] arg, input logic ad = 1'b0,
              input logic [7:0] nd = 8'h00);
        int n;
        cmd <= '{addressed: ad, node: nd, op: op, arg: arg};
        cmd_valid <= 1'b1;
        @(posedge mclk);
        for (n = 0; n < 50 && cmd_ready !== 1'b1; n++)
            @(posedge mclk);
        if (n == 50)
            fail_count++;
        cmd_valid <= 1'b0;
        @(posedge mclk);
    endtask : send
    function logic sig(input int s);
        case (s)
            0: return motion_valid;
            1: return nv_commit;
            2: return mem_free_valid;
            3: return prog_waiting;
            default: return !prog_running;
        endcase
    endfunction : sig
    // Bounded wait; a missed event counts as a mismatch
    task wait_for(input int s);
        int n;
        for (n = 0; n < 40 && sig(s) !== 1'b1; n++)
            @(posedge mclk);
        chk(n < 40, 1'b1);
    endtask : wait_for
    task settle;
        repeat (4) @(posedge mclk);
    endtask : settle
    task do_reset(input logic saved);
        autorun_saved <= saved;
        nrst <= 1'b0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_pin;
        spc_op_t ops[4] = '{op_set_pin_high, op_flip_pin_cmd, op_flip_pin_cmd,
                            op_clear_pin_low_cmd};
        logic lvl[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        err_level <= 1'b1;
        send(op_fault_pin_output_mode, 16'h0000);
        settle();
        chk(fault_pin, 1'b1);
        send(op_fault_pin_output_mode, 16'h0001);
        settle();
        chk(fault_pin, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            send(ops[i], 16'h0000);
            settle();
            chk(fault_pin, lvl[i]);
        end
        send(op_set_pin_high, 16'h0000, 1'b1, 8'h09);
        settle();
        chk(fault_pin, 1'b0);
        send(op_set_pin_high, 16'h0000, 1'b1, 8'h05);
        settle();
        chk(fault_pin, 1'b1);
    endtask : t_pin
    task t_capture;
        send(op_begin_program_capture, 16'h0000);
        send(op_move, 16'h0005);
        send(op_flip_pin_cmd, 16'h0000);
        send(op_hall_null_search, 16'h0000);
        settle();
        chk(fault_pin, 1'b1);
        send(op_end_marker, 16'h0000);
        wait_for(1);
        send(op_mem_query, 16'h0000);
        wait_for(2);
        chk(mem_free, 5'h0D);
    endtask : t_capture
    task t_readback(input logic mark);
        logic [7:0] exp_q[$];
        int n;
        exp_q = {8'h61 + 8'(op_move), 8'h0D, 8'h61 + 8'(op_flip_pin_cmd), 8'h0D,
                 8'h61 + 8'(op_hall_null_search), 8'h0D, 8'h65, 8'h6E, 8'h64, 8'h3A,
                 8'h30, 8'h36 + 8'(mark), 8'h0D, 8'h0A};
        if (mark)
            exp_q.push_front(8'h2A);
        host.rx_q.delete();
        slow <= 1'b1;
        send(op_read_back_program, {15'h0000, mark});
        for (n = 0; n < 600 && host.rx_q.size() < exp_q.size(); n++)
            @(posedge mclk);
        chk(host.rx_q.size(), exp_q.size());
        foreach (exp_q[i]) chk(host.rx_q[i], exp_q[i]);
        slow <= 1'b0;
    endtask : t_readback
    task t_run;
        send(op_fault_pin_output_mode, 16'h0001);
        send(op_run_program, 16'h0000);
        wait_for(0);
        chk(motion, {op_move, 16'h0005});
        wait_for(3);
        chk(fault_pin, 1'b1);
        send(op_clear_pin_low_cmd, 16'h0000);
        settle();
        chk(fault_pin, 1'b0);
        hall_null <= 1'b1;
        settle();
        chk(prog_waiting, 1'b0);
        hall_null <= 1'b0;
    endtask : t_run
    task t_autorun;
        do_reset(1'b1);
        chk(prog_running, 1'b1);
        wait_for(3);
        chk(motion, {op_move, 16'h0003});
        send(op_halt_program, 16'h0000);
        settle();
        chk(prog_running | prog_waiting, 1'b0);
        // Only the trailing toggle can raise the pin, so a restart from line 0 shows
        send(op_fault_pin_output_mode, 16'h0001);
        send(op_resume, 16'h0000);
        settle();
        chk(fault_pin, 1'b1);
        wait_for(4);
    endtask : t_autorun
    task t_notify;
        send(op_begin_program_capture, 16'h0000);
        send(op_wait_position_reached, 16'h0000);
        send(op_wait_speed_reached, 16'h0000);
        send(op_move, 16'h0003);
        // Trailing line keeps the program alive while it waits
        send(op_flip_pin_cmd, 16'h0000);
        send(op_end_marker, 16'h0000);
        send(op_run_program, 16'h0000);
        wait_for(3);
        settle();
        chk(prog_running, 1'b1);
        send(op_persist_settings, 16'h0000);
        settle();
        chk(nv_run_enable, 1'b1);
        speed_reached <= 1'b1;
        wait_for(4);
        chk(fault_pin, 1'b1);
        speed_reached <= 1'b0;
    endtask : t_notify

    ////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        close_out();
    end
    initial
    begin
        cmd_valid = 1'b0;
        cmd = '0;
        node_id = 8'h05;
        {autorun_saved, pos_reached, limit_passed, speed_reached} = 4'h0;
        {hall_null, err_level, slow, nrst} = 4'h0;
        fail_count = 0;
        compares = 0;
        do_reset(1'b0);
        t_pin();
        t_capture();
        t_readback(1'b0);
        do_reset(1'b0);
        t_readback(1'b1);
        t_run();
        t_notify();
        t_autorun();
        close_out();
    end
endmodule : tb_top
